/* File: rtl/bridge_cmd_pkg.sv */
// package: offsets, field positions, reset values and carriers of the command block
package bridge_cmd_pkg;

  // configuration dword offsets
  localparam logic [7:0] ID_OFFSET = 8'h00;
  localparam logic [7:0] CMD_OFFSET = 8'h04;

  // command field positions
  localparam int IO_EN_BIT = 0;
  localparam int MEM_EN_BIT = 1;
  localparam int MASTER_EN_BIT = 2;
  localparam int SPECIAL_BIT = 3;
  localparam int MWI_BIT = 4;
  localparam int PALETTE_BIT = 5;
  localparam int PARITY_BIT = 6;
  localparam int STEPPING_BIT = 7;
  localparam int SERR_EN_BIT = 8;
  localparam int FAST_B2B_BIT = 9;

  // writable command bits: 0,1,2,5,6,8,9
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0367;
  // every command bit comes out of reset clear
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // identification code, value is arbitrary
  localparam logic [15:0] DEVICE_CODE = 16'h5a5a;

  // palette snoop addresses, low ten address bits
  localparam logic [9:0] PALETTE_MASK_ADDR = 10'h3c6;
  localparam logic [9:0] PALETTE_WIDX_ADDR = 10'h3c8;
  localparam logic [9:0] PALETTE_DATA_ADDR = 10'h3c9;

  // configuration request from the host
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  // configuration answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

  // decoded bus cycle offered for a claim
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic is_write;
    logic [15:0] addr;
  } bus_cycle_t;

endpackage

/* File: rtl/palette_snoop_decode.sv */
// module: vga palette address match on the low ten i/o address bits
`timescale 1ns/10ps
`default_nettype none
module palette_snoop_decode (
  input wire logic [15:0] io_addr,
  output logic hit
);

  // bits 15:10 are aliases and left out of the compare
  always_comb
  begin
    hit = (io_addr[9:0] == bridge_cmd_pkg::PALETTE_MASK_ADDR)
       || (io_addr[9:0] == bridge_cmd_pkg::PALETTE_WIDX_ADDR)
       || (io_addr[9:0] == bridge_cmd_pkg::PALETTE_DATA_ADDR);
  end

endmodule // palette_snoop_decode
`default_nettype wire

/* File: rtl/bridge_primary_command_register.sv */
// module: primary id and command registers with the gating they apply
// Behaviour
// RULE_01: bit 0 gates claiming primary i/o cycles
// RULE_02: bit 1 gates claiming primary memory cycles
// RULE_03: bit 2 gates primary mastering, secondary claims
// RULE_04: bit 3 reads zero, read only
// RULE_05: bit 4 reads zero, read only
// RULE_06: bit 5 claims palette i/o writes
// RULE_07: bit 6 enables parity error reporting
// RULE_08: bit 7 reads zero, stepping disabled
// RULE_09: bit 8 enables system error driver
// RULE_10: bit 9 permits fast back-to-back transactions
// RULE_11: bits 15:10 read as zero
// RULE_12: device code fixed and read only
// RULE_13: writes to fixed bits have no effect
`timescale 1ns/10ps
`default_nettype none
module bridge_primary_command_register (
  input wire logic clk_sys,
  input wire logic reset,
  input wire bridge_cmd_pkg::cfg_req_t cfg_req,
  output bridge_cmd_pkg::cfg_rsp_t cfg_rsp,
  input wire bridge_cmd_pkg::bus_cycle_t prim_cycle,
  input wire bridge_cmd_pkg::bus_cycle_t sec_cycle,
  input wire logic fwd_request,
  input wire logic parity_error_seen,
  input wire logic system_error_event,
  output logic prim_claim,
  output logic sec_claim,
  output logic prim_master_start,
  output logic fast_b2b_allow,
  output logic parity_error_report,
  output logic stepping_enable,
  output logic primary_system_error_out_n,
  output logic primary_system_error_oe
);

  // whole module state in one record
  typedef struct packed {
    logic [15:0] cmd;
    bridge_cmd_pkg::cfg_rsp_t rsp;
    logic prim_claim;
    logic sec_claim;
    logic master_start;
    logic fast_b2b;
    logic parity_report;
    logic serr_drive;
    logic serr_level; // level put on the error pin while driven
  } state_t;

  state_t state_q; // registered state
  state_t state_d; // next state
  logic palette_hit; // low address matches a palette port
  logic [15:0] cmd_view; // command as read back
  logic [15:0] byte_mask; // bits selected by byte enables

  // palette address compare kept apart for reuse
  palette_snoop_decode palette_snoop_decode_inst (
    .io_addr(prim_cycle.addr),
    .hit(palette_hit)
  );

  // read view: only writable bits can be non-zero
  always_comb
  begin
    cmd_view = state_q.cmd & bridge_cmd_pkg::CMD_WRITE_MASK; // see RULE_04 see RULE_05 see RULE_11
    byte_mask = {{8{cfg_req.byte_en[1]}}, {8{cfg_req.byte_en[0]}}};
  end

  // next state
  always_comb
  begin
    state_d = state_q;
    state_d.rsp.ack = cfg_req.valid;
    state_d.rsp.rdata = 32'h0000_0000;
    // config access; unmapped offsets read zero and ignore writes
    if (cfg_req.valid)
    begin
      if (cfg_req.write)
      begin
        if (cfg_req.addr == bridge_cmd_pkg::CMD_OFFSET)
        begin
          // fixed bits never take the written value
          state_d.cmd = (state_q.cmd & ~(byte_mask & bridge_cmd_pkg::CMD_WRITE_MASK))
                      | (cfg_req.wdata[15:0] & byte_mask & bridge_cmd_pkg::CMD_WRITE_MASK); // see RULE_13
        end
      end
      else if (cfg_req.addr == bridge_cmd_pkg::ID_OFFSET)
      begin
        // vendor half is outside this block and reads zero here
        state_d.rsp.rdata = {bridge_cmd_pkg::DEVICE_CODE, 16'h0000}; // see RULE_12
      end
      else if (cfg_req.addr == bridge_cmd_pkg::CMD_OFFSET)
      begin
        // status half is outside this block and reads zero here
        state_d.rsp.rdata = {16'h0000, cmd_view}; // see RULE_11
      end
    end
    // primary claim: i/o, memory, or palette snoop writes
    state_d.prim_claim = prim_cycle.valid
      && ((prim_cycle.is_io && state_q.cmd[bridge_cmd_pkg::IO_EN_BIT]) // see RULE_01
       || (prim_cycle.is_mem && state_q.cmd[bridge_cmd_pkg::MEM_EN_BIT]) // see RULE_02
       || (prim_cycle.is_io && prim_cycle.is_write && palette_hit
           && state_q.cmd[bridge_cmd_pkg::PALETTE_BIT])); // see RULE_06
    // secondary claim and forwarding both need master enable
    state_d.sec_claim = sec_cycle.valid && (sec_cycle.is_io || sec_cycle.is_mem)
      && state_q.cmd[bridge_cmd_pkg::MASTER_EN_BIT]; // see RULE_03
    state_d.master_start = fwd_request && state_q.cmd[bridge_cmd_pkg::MASTER_EN_BIT]; // see RULE_03
    state_d.fast_b2b = state_q.cmd[bridge_cmd_pkg::FAST_B2B_BIT]; // see RULE_10
    // with response off, detected parity errors are dropped
    state_d.parity_report = parity_error_seen && state_q.cmd[bridge_cmd_pkg::PARITY_BIT]; // see RULE_07
    // open-drain driver only works when enabled
    state_d.serr_drive = system_error_event && state_q.cmd[bridge_cmd_pkg::SERR_EN_BIT]; // see RULE_09
    // open drain: only the low level is ever put on the pin
    state_d.serr_level = 1'b0; // see RULE_09
  end

  // register the state, synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= '0;
      state_q.cmd <= bridge_cmd_pkg::CMD_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // outputs straight from flops
  assign cfg_rsp = state_q.rsp;
  assign prim_claim = state_q.prim_claim;
  assign sec_claim = state_q.sec_claim;
  assign prim_master_start = state_q.master_start;
  assign fast_b2b_allow = state_q.fast_b2b;
  assign parity_error_report = state_q.parity_report;
  // stepping bit is fixed clear, so this reads the constant copy
  assign stepping_enable = state_q.cmd[bridge_cmd_pkg::STEPPING_BIT]; // see RULE_08
  assign primary_system_error_oe = state_q.serr_drive;
  // the pin is only ever pulled low; the enable decides when it is driven
  assign primary_system_error_out_n = state_q.serr_level;

  // checks; each gate is judged one cycle after the offer it answers
  io_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_01
    (prim_cycle.valid && prim_cycle.is_io && !prim_cycle.is_mem
     && !state_q.cmd[bridge_cmd_pkg::PALETTE_BIT]) |=>
    (prim_claim == $past(state_q.cmd[bridge_cmd_pkg::IO_EN_BIT])))
    else $error("io claim does not follow enable");
  mem_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_02
    (prim_cycle.valid && prim_cycle.is_mem && !prim_cycle.is_io) |=>
    (prim_claim == $past(state_q.cmd[bridge_cmd_pkg::MEM_EN_BIT])))
    else $error("memory claim does not follow enable");
  master_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
    (prim_master_start || sec_claim) |-> $past(state_q.cmd[bridge_cmd_pkg::MASTER_EN_BIT]))
    else $error("mastering without master enable");
  sec_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
    (sec_cycle.valid && sec_cycle.is_mem) |=>
    (sec_claim == $past(state_q.cmd[bridge_cmd_pkg::MASTER_EN_BIT])))
    else $error("secondary claim does not follow master enable");
  fixed_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_04
    (cfg_rsp.ack && $past(cfg_req.addr) == bridge_cmd_pkg::CMD_OFFSET)
    |-> (cfg_rsp.rdata[4:3] == 2'b00 && cfg_rsp.rdata[7] == 1'b0
         && cfg_rsp.rdata[31:10] == 22'h0))
    else $error("fixed command bits read non-zero");
  mwi_write_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_05
    (cfg_req.valid && cfg_req.write && cfg_req.addr == bridge_cmd_pkg::CMD_OFFSET)
    |=> !state_q.cmd[bridge_cmd_pkg::MWI_BIT])
    else $error("write and invalidate enable took a write");
  palette_hit_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_06
    (prim_cycle.valid && prim_cycle.is_io && prim_cycle.is_write && palette_hit
     && state_q.cmd[bridge_cmd_pkg::PALETTE_BIT]) |=> prim_claim)
    else $error("palette write not claimed");
  // snoop covers writes only; a read needs the i/o enable
  palette_read_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_06
    (prim_cycle.valid && prim_cycle.is_io && !prim_cycle.is_write && !prim_cycle.is_mem
     && !state_q.cmd[bridge_cmd_pkg::IO_EN_BIT]) |=> !prim_claim)
    else $error("i/o read claimed while disabled");
  parity_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_07
    parity_error_report |-> $past(parity_error_seen && state_q.cmd[bridge_cmd_pkg::PARITY_BIT]))
    else $error("parity report without response enable");
  parity_pass_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_07
    (parity_error_seen && state_q.cmd[bridge_cmd_pkg::PARITY_BIT]) |=> parity_error_report)
    else $error("parity error dropped while response enabled");
  stepping_off_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_08
    !stepping_enable)
    else $error("stepping enabled");
  serr_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
    primary_system_error_oe |-> $past(state_q.cmd[bridge_cmd_pkg::SERR_EN_BIT]))
    else $error("error pin driven while disabled");
  serr_pass_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
    (system_error_event && state_q.cmd[bridge_cmd_pkg::SERR_EN_BIT]) |=> primary_system_error_oe)
    else $error("error pin not driven while enabled");
  fast_b2b_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_10
    fast_b2b_allow |-> $past(state_q.cmd[bridge_cmd_pkg::FAST_B2B_BIT]))
    else $error("fast back-to-back without enable");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_11
    (cfg_rsp.ack && $past(!cfg_req.write && cfg_req.addr == bridge_cmd_pkg::CMD_OFFSET))
    |-> (cfg_rsp.rdata[15:10] == 6'h00))
    else $error("reserved command bits read non-zero");
  id_value_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
    (cfg_req.valid && !cfg_req.write && cfg_req.addr == bridge_cmd_pkg::ID_OFFSET)
    |=> (cfg_rsp.ack && cfg_rsp.rdata[31:16] == bridge_cmd_pkg::DEVICE_CODE))
    else $error("device code wrong");
  ro_write_a: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
    cfg_req.valid |=> ((state_q.cmd & ~bridge_cmd_pkg::CMD_WRITE_MASK) == 16'h0000))
    else $error("read-only command bit changed");

  // main scenarios
  cmd_write_c: cover property (@(posedge clk_sys) disable iff (reset)
    cfg_req.valid && cfg_req.write && cfg_req.addr == bridge_cmd_pkg::CMD_OFFSET);
  palette_claim_c: cover property (@(posedge clk_sys) disable iff (reset)
    prim_claim && $past(palette_hit));
  serr_drive_c: cover property (@(posedge clk_sys) disable iff (reset)
    primary_system_error_oe);
  master_start_c: cover property (@(posedge clk_sys) disable iff (reset)
    prim_master_start && sec_claim);
  parity_report_c: cover property (@(posedge clk_sys) disable iff (reset)
    parity_error_report);

endmodule // bridge_primary_command_register
`default_nettype wire

/* File: tb/cfg_host_model.sv */
// host model: issues configuration cycles and latches the answer
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
  input wire logic clk_sys,
  input wire bridge_cmd_pkg::cfg_req_t cmd,
  input wire bridge_cmd_pkg::cfg_rsp_t cfg_rsp,
  output bridge_cmd_pkg::cfg_req_t cfg_req,
  output logic got_ack,
  output logic [31:0] last_rdata
);
  // request for one cycle; between requests the qualifiers toggle so nothing stale is seen
  always_ff @(posedge clk_sys)
  begin
    cfg_req.valid <= cmd.valid;
    if (cmd.valid)
    begin
      cfg_req.write <= cmd.write;
      cfg_req.addr <= cmd.addr;
      cfg_req.byte_en <= cmd.byte_en;
      cfg_req.wdata <= cmd.wdata;
    end
    else
    begin
      cfg_req.write <= ~cfg_req.write;
      cfg_req.addr <= ~cfg_req.addr;
      cfg_req.byte_en <= ~cfg_req.byte_en;
      cfg_req.wdata <= ~cfg_req.wdata;
    end
    // answer taken at the edge where ack is high
    got_ack <= cfg_rsp.ack;
    if (cfg_rsp.ack)
    begin
      last_rdata <= cfg_rsp.rdata;
    end
  end
endmodule // cfg_host_model
`default_nettype wire

/* File: tb/bridge_primary_command_register_tb.sv */
// testbench: configuration access and gating of the primary command block
`timescale 1ns/10ps
`default_nettype none
module bridge_primary_command_register_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  bridge_cmd_pkg::cfg_req_t cmd = '0; // request handed to the host
  bridge_cmd_pkg::cfg_req_t cfg_req;
  bridge_cmd_pkg::cfg_rsp_t cfg_rsp;
  bridge_cmd_pkg::bus_cycle_t prim_cycle = '0;
  bridge_cmd_pkg::bus_cycle_t sec_cycle = '0;
  logic fwd_request = 1'b0;
  logic parity_error_seen = 1'b0;
  logic system_error_event = 1'b0;
  logic prim_claim, sec_claim, prim_master_start, fast_b2b_allow;
  logic parity_error_report, stepping_enable, primary_system_error_out_n;
  logic primary_system_error_oe, got_ack;
  logic [31:0] last_rdata;
  int miscompares = 0;
  int num_checks = 0;
  // 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  cfg_host_model cfg_host_model_inst (.clk_sys(clk_sys), .cmd(cmd), .cfg_rsp(cfg_rsp),
    .cfg_req(cfg_req), .got_ack(got_ack), .last_rdata(last_rdata));
  bridge_primary_command_register bridge_primary_command_register_inst (.clk_sys(clk_sys),
    .reset(reset), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .prim_cycle(prim_cycle),
    .sec_cycle(sec_cycle), .fwd_request(fwd_request), .parity_error_seen(parity_error_seen),
    .system_error_event(system_error_event), .prim_claim(prim_claim), .sec_claim(sec_claim),
    .prim_master_start(prim_master_start), .fast_b2b_allow(fast_b2b_allow),
    .parity_error_report(parity_error_report), .stepping_enable(stepping_enable),
    .primary_system_error_out_n(primary_system_error_out_n),
    .primary_system_error_oe(primary_system_error_oe));
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // 32-bit compare, used for read data
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // compare for single-bit gated outputs
  task automatic check_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  // one configuration cycle through the host; bounded wait for the answer
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, write: wr, addr: a, byte_en: be, wdata: wd};
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
    n = 0;
    while (got_ack !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (got_ack !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // read a dword and compare it
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'hf, 32'h0);
    check("rdata", exp, last_rdata);
  endtask
  // set command, offer one cycle on every path, judge each gated output
  task automatic gate(input logic [15:0] c, input logic [15:0] pa, input logic io);
    logic pal;
    pal = pa[9:0] == bridge_cmd_pkg::PALETTE_MASK_ADDR ||
      pa[9:0] == bridge_cmd_pkg::PALETTE_WIDX_ADDR || pa[9:0] == bridge_cmd_pkg::PALETTE_DATA_ADDR;
    cfg(1'b1, bridge_cmd_pkg::CMD_OFFSET, 4'h3, {16'h0, c});
    @(posedge clk_sys);
    prim_cycle <= '{valid: 1'b1, is_io: io, is_mem: !io, is_write: 1'b1, addr: pa};
    sec_cycle <= '{valid: 1'b1, is_io: 1'b0, is_mem: 1'b1, is_write: 1'b0, addr: 16'h0};
    fwd_request <= 1'b1;
    parity_error_seen <= 1'b1;
    system_error_event <= 1'b1;
    @(posedge clk_sys);
    prim_cycle <= '0;
    sec_cycle <= '0;
    fwd_request <= 1'b0;
    parity_error_seen <= 1'b0;
    system_error_event <= 1'b0;
    #1;
    check_bit("prim_claim", io ? (c[0] | (c[5] & pal)) : c[1], prim_claim);
    check_bit("sec_claim", c[2], sec_claim);
    check_bit("prim_master_start", c[2], prim_master_start);
    check_bit("parity_error_report", c[6], parity_error_report);
    check_bit("oe", c[8], primary_system_error_oe);
    check_bit("out_n", 1'b0, primary_system_error_out_n);
    check_bit("fast_b2b_allow", c[9], fast_b2b_allow);
    check_bit("stepping_enable", 1'b0, stepping_enable);
  endtask
  // reset values, fixed bits, byte lanes and the identification field
  task automatic reg_access();
    rd(bridge_cmd_pkg::ID_OFFSET, {bridge_cmd_pkg::DEVICE_CODE, 16'h0});
    rd(bridge_cmd_pkg::CMD_OFFSET, 32'h0);
    cfg(1'b1, bridge_cmd_pkg::CMD_OFFSET, 4'hf, 32'hffff_ffff);
    rd(bridge_cmd_pkg::CMD_OFFSET, 32'h0000_0367);
    cfg(1'b1, bridge_cmd_pkg::CMD_OFFSET, 4'h1, 32'h0);
    rd(bridge_cmd_pkg::CMD_OFFSET, 32'h0000_0300);
    cfg(1'b1, bridge_cmd_pkg::ID_OFFSET, 4'hf, 32'h1234_5678);
    rd(bridge_cmd_pkg::ID_OFFSET, {bridge_cmd_pkg::DEVICE_CODE, 16'h0});
  endtask
  // palette read with i/o off: the snoop claims writes only
  task automatic palette_read();
    cfg(1'b1, bridge_cmd_pkg::CMD_OFFSET, 4'h3, 32'h0000_0020);
    @(posedge clk_sys);
    prim_cycle <= '{valid: 1'b1, is_io: 1'b1, is_mem: 1'b0, is_write: 1'b0, addr: 16'h03c8};
    @(posedge clk_sys);
    prim_cycle <= '0;
    #1;
    check_bit("prim_claim", 1'b0, prim_claim);
  endtask
  // reset in mid-run must clear every writable command bit
  task automatic mid_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check_bit("fast_b2b_allow", 1'b0, fast_b2b_allow);
    check_bit("oe", 1'b0, primary_system_error_oe);
    rd(bridge_cmd_pkg::CMD_OFFSET, 32'h0);
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    reg_access();
    gate(16'h0000, 16'h03c8, 1'b1);
    gate(16'h0001, 16'h1234, 1'b1);
    gate(16'h0002, 16'h1234, 1'b0);
    gate(16'h0020, 16'hfc6, 1'b1);
    gate(16'h0020, 16'h7fc8, 1'b1);
    gate(16'h0020, 16'h03c9, 1'b1);
    gate(16'h0020, 16'h03c7, 1'b1);
    gate(16'h0344, 16'h1234, 1'b0);
    palette_read();
    gate(16'h0367, 16'h1234, 1'b1);
    mid_reset();
    conclude();
  end
endmodule // bridge_primary_command_register_tb
`default_nettype wire
